// [rtl/skr_pkg.sv]
// Package of offsets, fields, reset values and timing for skew report block.
package skr_pkg;
    // Register indices; the byte address is four times the index.
    localparam logic [7:0] IDX_CONFIG_ONE   = 8'h09;
    localparam logic [7:0] IDX_FAST_LINK    = 8'h1e;
    localparam logic [7:0] IDX_DEV_CTRL     = 8'h1f;
    localparam logic [7:0] IDX_SKEW_STATUS  = 8'h55;
    localparam logic [7:0] IDX_ALIGN_FIFO   = 8'he9;
    localparam logic [7:0] IDX_TDR_STATUS   = 8'h60;
    localparam logic [7:0] IDX_TDR_RESULT   = 8'h80;
    localparam logic [7:0] IDX_TDR_CROSS    = 8'ha0;
    // Field positions.
    localparam int CONFIG_ONE_AUTO_TDR_BIT  = 7;
    localparam int CTRL_RESTART_BIT   = 14;
    localparam int CTRL_TDR_START_BIT = 15;
    localparam int FL_FAST_EN_BIT     = 0;
    localparam int FL_CRIT_LSB        = 1;
    localparam int SKEW_SLAVE_LSB     = 0;
    localparam int SKEW_MASTER_LSB    = 4;
    localparam int SKEW_VALID_BIT     = 8;
    localparam int STAT_BUSY_BIT      = 12;
    localparam int STAT_DONE_BIT      = 13;
    // Reset values and the required alignment FIFO setting.
    localparam logic [15:0] CONFIG_ONE_RST = 16'h0000;
    localparam logic [15:0] FAST_LINK_RST  = 16'h0000;
    localparam logic [15:0] ALIGN_FIFO_RST = 16'h0000;
    localparam logic [15:0] ALIGN_FIFO_REQ = 16'hdf22;
    // Timing.
    localparam int CLK_PERIOD_NS   = 25;
    localparam int SKEW_UNIT_NS    = 8;
    localparam int LINK_WIN_GIG_NS = 500000;
    localparam int LINK_WIN_100_NS = 1000000;
    localparam int FAST_WIN_NS     = 10000;
    localparam int LINK_WIN_GIG_CYC = LINK_WIN_GIG_NS / CLK_PERIOD_NS;
    localparam int LINK_WIN_100_CYC = LINK_WIN_100_NS / CLK_PERIOD_NS;
    localparam int FAST_WIN_CYC     = FAST_WIN_NS / CLK_PERIOD_NS;
    // Reflectometry sequencer states.
    typedef enum logic [2:0] {
        SKR_IDLE, SKR_PULSE, SKR_LISTEN, SKR_STORE, SKR_DONE
    } skr_tdr_e;
endpackage

// [rtl/skr_top.sv]
// Skew report, cable reflectometry capture and link-loss window logic.
//
// Our own choice: the AHB-Lite register port.
`timescale 1ns/100ps
module skr_top #(
    parameter int PAIRS       = 4,
    parameter int MAX_REFL    = 5,
    parameter int AVG_LOG2    = 2,
    parameter int LISTEN_CYC  = 1024,
    parameter int WIN_GIG_CYC = skr_pkg::LINK_WIN_GIG_CYC,
    parameter int WIN_100_CYC = skr_pkg::LINK_WIN_100_CYC,
    parameter logic [3:0] SKEW_MAX = 4'hf
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        link_up,
    input  wire logic        speed_gig,
    input  wire logic        gig_master,
    input  wire logic [3:0]  align_skew,
    input  wire logic        sig_descr_lost,
    input  wire logic        sig_rx_err,
    input  wire logic        sig_mlt3_err,
    input  wire logic        sig_mse_bad,
    input  wire logic        sig_energy_lost,
    input  wire logic        refl_valid,
    input  wire logic [7:0]  refl_time,
    input  wire logic [7:0]  refl_amp,
    input  wire logic        refl_cross,
    output logic      [3:0]  tdr_pulse,
    output logic             soft_link_restart,
    output logic             link_drop
);
    import skr_pkg::*;

    localparam int NRES = PAIRS * MAX_REFL;
    localparam int ACCW = 8 + AVG_LOG2;

    // Refuse settings the storage and counters cannot serve.
    if (PAIRS != 4 || MAX_REFL < 2 || MAX_REFL > 7 || AVG_LOG2 > 4
        || LISTEN_CYC < 1 || LISTEN_CYC >= 2**20
        || WIN_GIG_CYC < 1 || WIN_GIG_CYC >= 2**20
        || WIN_100_CYC < 1 || WIN_100_CYC >= 2**20) begin : g_bad_param
        $error("skr_top: unsupported parameter value");
    end

    logic [15:0] config_one_q;
    logic [15:0] fast_link_q;
    logic [15:0] align_fifo_q;
    logic        fifo_armed_q;
    logic [15:0] skew_q;
    logic        link_up_q;
    logic        wr_q;
    logic [7:0]  widx_q;
    logic        restart_q;
    logic        tdr_start_q;
    logic        done_q;
    skr_tdr_e    st_q;
    logic [1:0]  pair_q;
    logic [AVG_LOG2:0] run_q;
    logic [19:0] tmr_q;
    logic [2:0]  slot_q;
    logic        xf_seen_q;
    logic [2:0]  cnt_q [PAIRS];
    logic [15:0] res_q [NRES];
    logic [8:0]  xf_q  [PAIRS];
    logic [ACCW-1:0] acc_t_q [MAX_REFL];
    logic [ACCW-1:0] acc_a_q [MAX_REFL];
    logic [19:0] loss_q;
    logic [15:0] rd_word;
    logic        addr_sel;
    logic        wr_en;
    logic        link_est;
    logic        link_fall;
    logic        loss_cond;
    logic [19:0] win_cyc;
    logic [2:0]  slot_lim;

    // Bus answers at once and always with OKAY.
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign addr_sel  = hsel & htrans[1] & hready;
    assign wr_en     = wr_q;

    // Link edges seen by the skew and auto-test logic.
    assign link_est  = link_up & ~link_up_q;
    assign link_fall = ~link_up & link_up_q;

    // Address phase capture and registered read data.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q   <= 1'b0;
            widx_q <= 8'h00;
            hrdata <= 32'h0000_0000;
        end else begin
            wr_q <= addr_sel & hwrite;
            if (addr_sel) begin
                widx_q <= haddr[9:2];
            end
            if (addr_sel && !hwrite) begin
                hrdata <= {16'h0000, rd_word};
            end
        end
    end

    // Read multiplexer; unmapped words read as zero.
    always_comb begin
        rd_word = 16'h0000;
        if (haddr[31:10] == 22'h0) begin
            unique case (haddr[9:2])
                IDX_CONFIG_ONE:  rd_word = config_one_q;
                IDX_FAST_LINK:   rd_word = fast_link_q;
                IDX_DEV_CTRL:    rd_word = 16'h0000;
                IDX_SKEW_STATUS: rd_word = skew_q;
                IDX_ALIGN_FIFO:  rd_word = align_fifo_q;
                IDX_TDR_STATUS: begin
                    rd_word[STAT_BUSY_BIT] = (st_q != SKR_IDLE);
                    rd_word[STAT_DONE_BIT] = done_q;
                    for (int p = 0; p < PAIRS; p++) begin
                        rd_word[p*3 +: 3] = cnt_q[p];
                    end
                end
                default: begin
                    for (int i = 0; i < NRES; i++) begin
                        if (haddr[9:2] == IDX_TDR_RESULT + 8'(i)) begin
                            rd_word = res_q[i];
                        end
                    end
                    for (int p = 0; p < PAIRS; p++) begin
                        if (haddr[9:2] == IDX_TDR_CROSS + 8'(p)) begin
                            rd_word = {7'h00, xf_q[p]};
                        end
                    end
                end
            endcase
        end
    end

    // Software configuration registers.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            config_one_q <= CONFIG_ONE_RST;
            fast_link_q  <= FAST_LINK_RST;
            align_fifo_q <= ALIGN_FIFO_RST;
        end else if (wr_en) begin
            if (widx_q == IDX_CONFIG_ONE) begin
                config_one_q <= hwdata[15:0];
            end
            if (widx_q == IDX_FAST_LINK) begin
                fast_link_q <= hwdata[15:0];
            end
            if (widx_q == IDX_ALIGN_FIFO) begin
                align_fifo_q <= hwdata[15:0];
            end
        end
    end

    // Arm skew reporting once the FIFO holds the required value.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fifo_armed_q <= 1'b0;
        end else if (wr_en && widx_q == IDX_ALIGN_FIFO) begin
            fifo_armed_q <= (hwdata[15:0] == ALIGN_FIFO_REQ);
        end
    end

    // Control writes: restart pulse and test start, both self-clearing.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            restart_q   <= 1'b0;
            tdr_start_q <= 1'b0;
        end else begin
            restart_q   <= wr_en && widx_q == IDX_DEV_CTRL
                           && hwdata[CTRL_RESTART_BIT];
            tdr_start_q <= (wr_en && widx_q == IDX_DEV_CTRL
                            && hwdata[CTRL_TDR_START_BIT])
                           || (link_fall
                               && config_one_q[CONFIG_ONE_AUTO_TDR_BIT]);
        end
    end
    assign soft_link_restart = restart_q;

    // Skew captured once per gigabit link and held until it drops.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            link_up_q <= 1'b0;
            skew_q    <= 16'h0000;
        end else begin
            link_up_q <= link_up;
            if (link_fall) begin
                skew_q <= 16'h0000;
            end else if (link_est && speed_gig && fifo_armed_q) begin
                skew_q <= 16'h0000;
                skew_q[SKEW_VALID_BIT] <= 1'b1;
                if (gig_master) begin
                    skew_q[SKEW_MASTER_LSB +: 4] <= (align_skew > SKEW_MAX)
                        ? SKEW_MAX : align_skew;
                end else begin
                    skew_q[SKEW_SLAVE_LSB +: 4] <= (align_skew > SKEW_MAX)
                        ? SKEW_MAX : align_skew;
                end
            end
            // A link at 100M leaves the fields at zero.
        end
    end

    // Reflections kept per run: five, or four once a cross fault is seen.
    assign slot_lim = xf_seen_q ? 3'(MAX_REFL - 1) : 3'(MAX_REFL);

    // Reflectometry sequencer: pulse, listen, repeat, then average.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q      <= SKR_IDLE;
            pair_q    <= 2'd0;
            run_q     <= '0;
            tmr_q     <= 20'd0;
            slot_q    <= 3'd0;
            xf_seen_q <= 1'b0;
            done_q    <= 1'b0;
        end else begin
            unique case (st_q)
                SKR_IDLE: begin
                    if (tdr_start_q) begin
                        done_q    <= 1'b0;
                        pair_q    <= 2'd0;
                        run_q     <= '0;
                        xf_seen_q <= 1'b0;
                        st_q      <= SKR_PULSE;
                    end
                end
                SKR_PULSE: begin
                    slot_q <= 3'd0;
                    tmr_q  <= 20'(LISTEN_CYC - 1);
                    st_q   <= SKR_LISTEN;
                end
                SKR_LISTEN: begin
                    if (refl_valid && refl_cross) begin
                        xf_seen_q <= 1'b1;
                    end else if (refl_valid && slot_q < slot_lim) begin
                        slot_q <= slot_q + 3'd1;
                    end
                    if (tmr_q == 20'd0) begin
                        run_q <= run_q + 1'b1;
                        st_q  <= (run_q == (AVG_LOG2+1)'(2**AVG_LOG2 - 1))
                                 ? SKR_STORE : SKR_PULSE;
                    end else begin
                        tmr_q <= tmr_q - 20'd1;
                    end
                end
                SKR_STORE: begin
                    run_q     <= '0;
                    xf_seen_q <= 1'b0;
                    pair_q    <= pair_q + 2'd1;
                    st_q <= (pair_q == 2'(PAIRS - 1)) ? SKR_DONE : SKR_PULSE;
                end
                SKR_DONE: begin
                    done_q <= 1'b1;
                    st_q   <= SKR_IDLE;
                end
            endcase
        end
    end

    // One test pulse on the pair under test.
    always_comb begin
        tdr_pulse = 4'h0;
        if (st_q == SKR_PULSE) begin
            tdr_pulse[pair_q] = 1'b1;
        end
    end

    // Accumulate time and amplitude of each reflection slot over runs.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < MAX_REFL; i++) begin
                acc_t_q[i] <= '0;
                acc_a_q[i] <= '0;
            end
        end else if (st_q == SKR_STORE || st_q == SKR_IDLE) begin
            for (int i = 0; i < MAX_REFL; i++) begin
                acc_t_q[i] <= '0;
                acc_a_q[i] <= '0;
            end
        end else if (st_q == SKR_LISTEN && refl_valid && !refl_cross
                     && slot_q < slot_lim) begin
            acc_t_q[slot_q] <= acc_t_q[slot_q] + ACCW'(refl_time);
            acc_a_q[slot_q] <= acc_a_q[slot_q] + ACCW'(refl_amp);
        end
    end

    // Store averaged results, counts and cross-fault locations per pair.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < NRES; i++) begin
                res_q[i] <= 16'h0000;
            end
            for (int p = 0; p < PAIRS; p++) begin
                cnt_q[p] <= 3'd0;
                xf_q[p]  <= 9'h000;
            end
        end else if (st_q == SKR_LISTEN && refl_valid && refl_cross
                     && !xf_seen_q && !xf_q[pair_q][8]) begin
            xf_q[pair_q] <= {1'b1, refl_time};
        end else if (st_q == SKR_STORE) begin
            cnt_q[pair_q] <= slot_q;
            for (int i = 0; i < MAX_REFL; i++) begin
                res_q[int'(pair_q)*MAX_REFL + i] <=
                    {acc_a_q[i][AVG_LOG2 +: 8], acc_t_q[i][AVG_LOG2 +: 8]};
            end
        end else if (st_q == SKR_IDLE && tdr_start_q) begin
            for (int p = 0; p < PAIRS; p++) begin
                xf_q[p] <= 9'h000;
            end
        end
    end

    // Loss condition: fast mode uses the selected criteria.
    always_comb begin
        loss_cond = sig_energy_lost | sig_descr_lost;
        win_cyc   = speed_gig ? 20'(WIN_GIG_CYC) : 20'(WIN_100_CYC);
        if (fast_link_q[FL_FAST_EN_BIT]) begin
            loss_cond = |(fast_link_q[FL_CRIT_LSB +: 5] &
                {sig_energy_lost, sig_mse_bad, sig_mlt3_err,
                 sig_rx_err, sig_descr_lost});
            win_cyc   = 20'(FAST_WIN_CYC);
        end
    end

    // Search window counter; a drop pulses once when it expires.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            loss_q    <= 20'd0;
            link_drop <= 1'b0;
        end else begin
            link_drop <= 1'b0;
            if (!link_up || !loss_cond) begin
                loss_q <= 20'd0;
            end else if (loss_q == win_cyc - 20'd1) begin
                loss_q    <= 20'd0;
                link_drop <= 1'b1;
            end else begin
                loss_q <= loss_q + 20'd1;
            end
        end
    end

endmodule

// [bench/skr_top_monitor.sv]
// Checker of bus answer, pulse and link-loss timing at the block's ports.
`timescale 1ns/100ps
module skr_top_monitor
    import skr_pkg::*;
(
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hwdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        link_up,
    input wire logic        sig_descr_lost,
    input wire logic        sig_rx_err,
    input wire logic        sig_mlt3_err,
    input wire logic        sig_mse_bad,
    input wire logic        sig_energy_lost,
    input wire logic [3:0]  tdr_pulse,
    input wire logic        soft_link_restart,
    input wire logic        link_drop
);
    logic       wr_q;
    logic [7:0] widx_q;
    logic       auto_q;
    logic       loss_a;
    // Any loss condition, whichever mode selects it.
    assign loss_a = sig_descr_lost | sig_rx_err | sig_mlt3_err
                  | sig_mse_bad | sig_energy_lost;
    // Data phases of writes, and the auto-test enable they leave behind.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q   <= 1'b0;
            widx_q <= 8'h00;
            auto_q <= 1'b0;
        end else begin
            wr_q   <= hsel & htrans[1] & hready & hwrite;
            widx_q <= haddr[9:2];
            if (wr_q && widx_q == IDX_CONFIG_ONE) begin
                auto_q <= hwdata[CONFIG_ONE_AUTO_TDR_BIT];
            end
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence quiet_s; (tdr_pulse == 4'h0) [*8]; endsequence
    sequence restart_s; wr_q && widx_q == IDX_DEV_CTRL
        && hwdata[CTRL_RESTART_BIT]; endsequence
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus answer not ready or not okay");
    a_restart_pulse: assert property (restart_s |=> ##[0:1] soft_link_restart)
        else $error("restart write gave no restart pulse");
    a_restart_single: assert property (soft_link_restart |=> !soft_link_restart)
        else $error("restart pulse longer than one cycle");
    a_pair_onehot: assert property ($onehot0(tdr_pulse))
        else $error("test pulse on more than one pair");
    a_pulse_quiet: assert property (tdr_pulse != 4'h0 |=> quiet_s)
        else $error("test pulse repeated inside listen time");
    a_auto_start: assert property ($fell(link_up) && auto_q |-> ##[1:6] tdr_pulse[0])
        else $error("no automatic test after link failure");
    a_drop_cause: assert property (link_drop |-> $past(link_up) && $past(loss_a))
        else $error("link drop without link or loss condition");
    a_drop_single: assert property (link_drop |=> !link_drop)
        else $error("link drop longer than one cycle");
endmodule
bind skr_top skr_top_monitor u_mon (.hclk, .hresetn, .hsel, .haddr, .htrans,
    .hwrite, .hready, .hwdata, .hreadyout, .hresp, .link_up, .sig_descr_lost,
    .sig_rx_err, .sig_mlt3_err, .sig_mse_bad, .sig_energy_lost, .tdr_pulse,
    .soft_link_restart, .link_drop);

// [bench/skr_partner.sv]
// Cable model that returns reflections after each test pulse.
`timescale 1ns/100ps
module skr_partner (
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic [3:0] tdr_pulse,
    input  wire logic [2:0] n_refl,
    input  wire logic [2:0] cross_at,
    output logic            refl_valid,
    output logic [7:0]      refl_time,
    output logic [7:0]      refl_amp,
    output logic            refl_cross
);
    logic [4:0] t_q;
    logic [1:0] p_q;
    logic       odd_q;
    logic [7:0] f_q;
    logic [2:0] k;
    // Cycles since the last pulse, its pair, run parity, idle pattern.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            t_q   <= 5'h1f;
            p_q   <= 2'h0;
            odd_q <= 1'b1;
            f_q   <= 8'h00;
        end else begin
            f_q <= f_q + 8'h01;
            if (tdr_pulse != 4'h0) begin
                t_q   <= 5'h00;
                odd_q <= ~odd_q;
                p_q   <= {tdr_pulse[3] | tdr_pulse[2], tdr_pulse[3] | tdr_pulse[1]};
            end else if (t_q != 5'h1f) begin
                t_q <= t_q + 5'h01;
            end
        end
    end
    // Reflections come only after a pulse; the line is quiet otherwise.
    assign k          = t_q[3:1] - 3'd1;
    assign refl_valid = !t_q[4] && !t_q[0] && t_q[3:1] != 3'd0 && t_q[3:1] <= n_refl;
    assign refl_cross = refl_valid && k == cross_at;
    // Odd runs arrive two later, so only an average gives the midpoint, one above the even runs.
    assign refl_time  = refl_valid ? 8'h10 + {2'b0, k, 3'b0} + {6'b0, p_q}
                      + (refl_cross ? 8'h00 : {6'b0, odd_q, 1'b0}) : ~f_q;
    assign refl_amp   = refl_valid ? 8'h40 + {5'b0, k} : f_q;
endmodule

// [bench/skr_top_bench.sv]
// Self-checking bench for the skew report block.
`timescale 1ns/100ps
module skr_top_bench;
    import skr_pkg::*;
    logic        hclk, hresetn, hsel, hwrite, link_up, speed_gig, gig_master;
    logic        hreadyout, hresp, refl_valid, refl_cross, soft_link_restart, link_drop;
    logic [31:0] haddr, hwdata, hrdata, st, rd, seed;
    logic [1:0]  htrans;
    logic [2:0]  hsize, n_refl, cross_at;
    logic [3:0]  align_skew, tdr_pulse;
    logic [4:0]  sig;
    logic [7:0]  refl_time, refl_amp;
    logic [11:0] cprev;
    logic [7:0]  regs [4] = '{IDX_CONFIG_ONE, IDX_FAST_LINK, IDX_ALIGN_FIFO, IDX_SKEW_STATUS};
    int          miscompares, checks, n_rs, n_tp, n;
    wire logic   hready = hreadyout;
    skr_top #(.LISTEN_CYC(24), .WIN_GIG_CYC(50), .WIN_100_CYC(100), .SKEW_MAX(4'ha)) uut (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
        .hrdata, .hreadyout, .hresp, .link_up, .speed_gig, .gig_master, .align_skew,
        .sig_descr_lost(sig[0]), .sig_rx_err(sig[1]), .sig_mlt3_err(sig[2]),
        .sig_mse_bad(sig[3]), .sig_energy_lost(sig[4]), .refl_valid, .refl_time,
        .refl_amp, .refl_cross, .tdr_pulse, .soft_link_restart, .link_drop);
    skr_partner u_cab (.hclk, .hresetn, .tdr_pulse, .n_refl, .cross_at,
        .refl_valid, .refl_time, .refl_amp, .refl_cross);
    // Clock at 40 MHz.
    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end
    // Restart pulses and test pulses seen since reset.
    always @(posedge hclk) begin
        n_rs += soft_link_restart;
        n_tp += (tdr_pulse != 4'h0);
    end
    function logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Reported skew is clamped and lands in the nibble of the role.
    function logic [31:0] skexp(logic ms, logic [3:0] s);
        logic [3:0] c;
        c = s > 4'ha ? 4'ha : s;
        return ms ? {24'h001, c, 4'h0} : {28'h0010, c};
    endfunction
    // Stored reflection k of pair p: amplitude above the averaged time.
    function logic [31:0] rexp(int k, int p);
        return {16'h0, 8'h40 + 8'(k), 8'h11 + 8'(8 * k + p)};
    endfunction
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task print_verdict();
        if (miscompares == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // One single transfer: address phase, then data phase.
    task bus(input logic wr, input logic [7:0] idx, input logic [15:0] wd);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr  <= {22'h0, idx, 2'b00};
        do @(posedge hclk); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {16'h0, wd};
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task rc(input logic [7:0] idx, input logic [31:0] exp);
        bus(1'b0, idx, 16'h0);
        chk(rd, exp);
    endtask
    // A link comes up, the input skew moves, software pokes, link drops.
    task sk_run(input logic gig, input logic ms, input logic ini, input logic [3:0] s);
        logic [31:0] e;
        e = (gig && ini) ? skexp(ms, s) : 32'h0;
        speed_gig  <= gig;
        gig_master <= ms;
        align_skew <= s;
        @(posedge hclk);
        link_up <= 1'b1;
        repeat (3) @(posedge hclk);
        rc(IDX_SKEW_STATUS, e);
        align_skew <= ~s;
        bus(1'b1, IDX_SKEW_STATUS, 16'hffff);
        rc(IDX_SKEW_STATUS, e);
        link_up <= 1'b0;
        repeat (3) @(posedge hclk);
        rc(IDX_SKEW_STATUS, 32'h0);
    endtask
    // One reflectometry run, by software or by a failing link; nr reflections, cross fault at ca.
    task reflectometry_test(input logic autom, input logic [2:0] nr, input logic [2:0] ca, input logic [2:0] c);
        n_refl   <= nr;
        cross_at <= ca;
        if (autom) begin
            bus(1'b1, IDX_CONFIG_ONE, 16'h0080);
            link_up <= 1'b1;
            repeat (4) @(posedge hclk);
            link_up <= 1'b0;
            repeat (4) @(posedge hclk);
        end else bus(1'b1, IDX_DEV_CTRL, 16'h8000);
        rc(IDX_TDR_STATUS, 32'h1000 | 32'(cprev));
        n = 0;
        do begin
            bus(1'b0, IDX_TDR_STATUS, 16'h0);
            n++;
        end while (rd[13] !== 1'b1 && n < 400);
        chk(rd, {19'h1, 1'b0, c, c, c, c});
        cprev = {c, c, c, c};
        bus(1'b1, IDX_CONFIG_ONE, 16'h0);
    endtask
    // A loss condition held for some cycles; win 0 means no drop wanted.
    task loss(input logic gig, input logic [15:0] cfg, input logic [4:0] s, input int hold, input int win);
        bus(1'b1, IDX_FAST_LINK, cfg);
        speed_gig <= gig;
        link_up   <= 1'b1;
        repeat (2) @(posedge hclk);
        sig <= s;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (link_drop !== 1'b1 && n < hold);
        sig <= 5'h0;
        chk({31'h0, win > 0 ? link_drop === 1'b1 && n > win - 2 && n < win + 4
                            : link_drop !== 1'b1}, 32'h1);
        link_up <= 1'b0;
        repeat (2) @(posedge hclk);
    endtask
    // Cuts a hang short.
    initial begin
        repeat (30000) @(posedge hclk);
        miscompares++;
        print_verdict();
    end
    // Main sequence.
    initial begin
        {miscompares, checks, n_rs, n_tp} = '0;
        cprev = 12'h000;
        seed = 32'd29824;
        {hresetn, hsel, htrans, hwrite, haddr, hwdata, sig} = '0;
        {link_up, speed_gig, gig_master, align_skew, n_refl} = '0;
        hsize    = 3'b010;
        cross_at = 3'h7;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        foreach (regs[i]) rc(regs[i], 32'h0);
        bus(1'b1, 8'h33, 16'hbeef);
        rc(8'h33, 32'h0);
        for (int i = 0; i < 3; i++) begin
            st = xs();
            bus(1'b1, regs[i], st[15:0]);
            rc(regs[i], {16'h0, st[15:0]});
        end
        bus(1'b1, IDX_CONFIG_ONE, 16'h0);
        bus(1'b1, IDX_ALIGN_FIFO, ALIGN_FIFO_REQ);
        for (int i = 0; i < 6; i++) begin
            st = xs();
            sk_run(1'b1, i[0], 1'b1, i == 0 ? 4'hf : st[3:0]);
        end
        sk_run(1'b0, 1'b0, 1'b1, 4'h3);
        bus(1'b1, IDX_ALIGN_FIFO, 16'h1234);
        sk_run(1'b1, 1'b1, 1'b0, 4'h5);
        gig_master <= 1'b0;
        align_skew <= 4'h7;
        link_up    <= 1'b1;
        bus(1'b1, IDX_ALIGN_FIFO, ALIGN_FIFO_REQ);
        bus(1'b1, IDX_DEV_CTRL, 16'h4000);
        repeat (3) @(posedge hclk);
        chk(32'(n_rs), 32'h1);
        link_up <= 1'b0;
        repeat (3) @(posedge hclk);
        link_up <= 1'b1;
        repeat (3) @(posedge hclk);
        rc(IDX_SKEW_STATUS, 32'h107);
        link_up <= 1'b0;
        st = xs();
        reflectometry_test(1'b0, {1'b0, st[1:0]}, 3'h7, {1'b0, st[1:0]});
        reflectometry_test(1'b0, 3'd7, 3'h7, 3'd5);
        for (int p = 0; p < 4; p++) rc(8'(IDX_TDR_RESULT + p * 5 + 4), rexp(4, p));
        reflectometry_test(1'b1, 3'd7, 3'd1, 3'd4);
        for (int p = 0; p < 4; p++) begin
            rc(8'(IDX_TDR_CROSS + p), 32'h118 + 32'(p));
            rc(8'(IDX_TDR_RESULT + p * 5 + 1), rexp(2, p));
        end
        chk(32'(n_tp), 32'd48);
        loss(1'b1, 16'h0, 5'h10, 80, 50);
        loss(1'b0, 16'h0, 5'h01, 150, 100);
        loss(1'b1, 16'h0, 5'h10, 30, 0);
        loss(1'b1, 16'h0, 5'h02, 80, 0);
        for (int i = 0; i < 5; i++) begin
            loss(1'b1, 16'h1 | 16'(2 << i), 5'(1 << i), FAST_WIN_CYC + 50, FAST_WIN_CYC);
        end
        st = xs();
        loss(1'b1, 16'h3f & ~16'(2 << (st % 5)), 5'(1 << (st % 5)), 450, 0);
        rc(IDX_TDR_CROSS, 32'h118);
        print_verdict();
    end
endmodule
